// [swwc_cfg.svh]
// Contract
// - sleep instruction enters standby when standby select is 1, else sleep, subsleep, or a direct transfer to active or subactive.
// - after interrupt wake from standby, subsleep or subactive with low speed 0, the cpu alone holds off for the programmed wait; wake from sleep has no wait.
//   only cpu_hold is driven for the wait; the watch clock sampler and the registers keep running.
// - wake wait select gives 8192,16384,32768,65536,131072,1024,128,16 states.
// - watch clock sampled at osc/16 when rate select is 0, osc/4 when 1.
// - three reserved low bits of power control one read zero, reset zero.
// - low-power mode decided by standby select plus companion sleep kind, low speed, direct bits.
`ifndef SWWC_CFG_SVH
`define SWWC_CFG_SVH
`define SWWC_OFF_PCR1 12'h000
`define SWWC_OFF_PCR2 12'h004
`define SWWC_OFF_STAT 12'h008
`define SWWC_BIT_STDBY 7
`define SWWC_BIT_WW_HI 6
`define SWWC_BIT_WW_LO 4
`define SWWC_BIT_NSR 3
`define SWWC_BIT_SKS 7
`define SWWC_BIT_LSF 6
`define SWWC_BIT_DTF 5
`define SWWC_PCR1_WMASK 8'hf8
`define SWWC_PCR2_WMASK 8'he0
`define SWWC_PCR_RESET 8'h00
`define SWWC_DIV_SLOW 5'h10
`define SWWC_DIV_FAST 5'h04
`define SWWC_WAIT_S0 18'h02000
`define SWWC_WAIT_S1 18'h04000
`define SWWC_WAIT_S2 18'h08000
`define SWWC_WAIT_S3 18'h10000
`define SWWC_WAIT_S4 18'h20000
`define SWWC_WAIT_S5 18'h00400
`define SWWC_WAIT_S6 18'h00080
`define SWWC_WAIT_S7 18'h00010
`endif

// [swwc_pkg.sv]
package swwc_pkg;
    typedef enum logic [5:0] {
        SWWC_ACTIVE = 6'b000001,
        SWWC_SLEEP = 6'b000010,
        SWWC_SUBSLEEP = 6'b000100,
        SWWC_STANDBY = 6'b001000,
        SWWC_SUBACTIVE = 6'b010000,
        SWWC_WAKE_WAIT = 6'b100000
    } swwc_mode_t;
endpackage : swwc_pkg

// [swwc_sampler.sv]
`timescale 1ns/1ps
`include "swwc_cfg.svh"
module swwc_sampler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fast_rate,
    input wire logic watch_clk_in,
    output logic watch_clk_sampled,
    output logic sample_tick
);
    logic [4:0] div_ff;
    logic [4:0] nxt_div;
    logic tick_ff;
    logic nxt_tick;
    logic [2:0] sync_ff;
    logic [2:0] nxt_sync;
    logic samp_ff;
    logic nxt_samp;
    logic [4:0] limit;

    always_comb begin
        limit = fast_rate ? `SWWC_DIV_FAST : `SWWC_DIV_SLOW;
        nxt_tick = 1'b0;
        nxt_div = div_ff + 5'd1;
        if (div_ff >= limit - 5'd1) begin
            nxt_div = 5'd0;
            nxt_tick = 1'b1;
        end
        nxt_sync = {sync_ff[1:0], watch_clk_in};
        nxt_samp = samp_ff;
        // only accept a level once stages two and three agree, on the sample tick
        if (tick_ff && (sync_ff[1] == sync_ff[2])) begin
            nxt_samp = sync_ff[2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 5'd0;
            tick_ff <= 1'b0;
            sync_ff <= 3'b000;
            samp_ff <= 1'b0;
        end else begin
            div_ff <= nxt_div;
            tick_ff <= nxt_tick;
            sync_ff <= nxt_sync;
            samp_ff <= nxt_samp;
        end
    end

    assign watch_clk_sampled = samp_ff;
    assign sample_tick = tick_ff;
endmodule : swwc_sampler

// [swwc_top.sv]
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "swwc_cfg.svh"
module swwc_top #(
    parameter int unsigned CNT_W = 18
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_exec,
    input wire logic wake_irq,
    input wire logic watch_clk_in,
    output logic cpu_hold,
    output logic [5:0] mode_out,
    output logic watch_clk_sampled,
    output logic sample_tick
);
    logic [7:0] pcr1_ff;
    logic [7:0] nxt_pcr1;
    logic [7:0] pcr2_ff;
    logic [7:0] nxt_pcr2;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    swwc_pkg::swwc_mode_t mode_ff;
    swwc_pkg::swwc_mode_t nxt_mode;
    swwc_pkg::swwc_mode_t tgt_ff;
    swwc_pkg::swwc_mode_t nxt_tgt;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic hold_ff;
    logic nxt_hold;
    logic samp_w;
    logic tick_w;
    logic setup;

    function automatic logic [CNT_W-1:0] wait_states(input logic [2:0] sel);
        case (sel)
            3'b000: wait_states = CNT_W'(`SWWC_WAIT_S0);
            3'b001: wait_states = CNT_W'(`SWWC_WAIT_S1);
            3'b010: wait_states = CNT_W'(`SWWC_WAIT_S2);
            3'b011: wait_states = CNT_W'(`SWWC_WAIT_S3);
            3'b100: wait_states = CNT_W'(`SWWC_WAIT_S4);
            3'b101: wait_states = CNT_W'(`SWWC_WAIT_S5);
            3'b110: wait_states = CNT_W'(`SWWC_WAIT_S6);
            default: wait_states = CNT_W'(`SWWC_WAIT_S7);
        endcase
    endfunction : wait_states

    // zero-wait apb: answer in the cycle after setup
    always_comb begin
        setup = psel && !penable;
        nxt_pcr1 = pcr1_ff;
        nxt_pcr2 = pcr2_ff;
        nxt_pready = setup;
        nxt_pslverr = 1'b0;
        nxt_prdata = prdata_ff;
        if (setup) begin
            nxt_prdata = 32'h0000_0000;
            case (paddr)
                `SWWC_OFF_PCR1: begin
                    if (pwrite) begin
                        nxt_pcr1 = pwdata[7:0] & `SWWC_PCR1_WMASK;
                    end
                    nxt_prdata = {24'h00_0000, pcr1_ff & `SWWC_PCR1_WMASK};
                end
                `SWWC_OFF_PCR2: begin
                    if (pwrite) begin
                        nxt_pcr2 = pwdata[7:0] & `SWWC_PCR2_WMASK;
                    end
                    nxt_prdata = {24'h00_0000, pcr2_ff};
                end
                `SWWC_OFF_STAT: begin
                    nxt_prdata = {24'h00_0000, hold_ff, 1'b0, mode_ff};
                end
                default: begin
                    nxt_pslverr = 1'b1;
                end
            endcase
        end
    end

    // sleep entry, wake and stabilisation wait
    always_comb begin
        nxt_mode = mode_ff;
        nxt_tgt = tgt_ff;
        nxt_cnt = cnt_ff;
        nxt_hold = hold_ff;
        case (mode_ff)
            swwc_pkg::SWWC_ACTIVE, swwc_pkg::SWWC_SUBACTIVE: begin
                if (sleep_exec) begin
                    if (pcr1_ff[`SWWC_BIT_STDBY]) begin
                        nxt_mode = swwc_pkg::SWWC_STANDBY;
                    end else if (pcr2_ff[`SWWC_BIT_DTF]) begin
                        nxt_mode = pcr2_ff[`SWWC_BIT_LSF] ? swwc_pkg::SWWC_SUBACTIVE : swwc_pkg::SWWC_ACTIVE;
                    end else if (pcr2_ff[`SWWC_BIT_SKS]) begin
                        nxt_mode = swwc_pkg::SWWC_SUBSLEEP;
                    end else begin
                        nxt_mode = swwc_pkg::SWWC_SLEEP;
                    end
                end else if (wake_irq && mode_ff == swwc_pkg::SWWC_SUBACTIVE && !pcr2_ff[`SWWC_BIT_LSF]) begin
                    nxt_tgt = swwc_pkg::SWWC_ACTIVE;
                    nxt_mode = swwc_pkg::SWWC_WAKE_WAIT;
                    nxt_hold = 1'b1;
                    nxt_cnt = '0;
                end
            end
            swwc_pkg::SWWC_SLEEP: begin
                if (wake_irq) begin
                    nxt_mode = swwc_pkg::SWWC_ACTIVE;
                end
            end
            swwc_pkg::SWWC_STANDBY, swwc_pkg::SWWC_SUBSLEEP: begin
                if (wake_irq) begin
                    // oscillator was stopped, so hold the cpu off
                    nxt_tgt = (mode_ff == swwc_pkg::SWWC_SUBSLEEP && pcr2_ff[`SWWC_BIT_LSF]) ?
                        swwc_pkg::SWWC_SUBACTIVE : swwc_pkg::SWWC_ACTIVE;
                    nxt_mode = swwc_pkg::SWWC_WAKE_WAIT;
                    nxt_hold = 1'b1;
                    nxt_cnt = '0;
                end
            end
            swwc_pkg::SWWC_WAKE_WAIT: begin
                nxt_cnt = cnt_ff + CNT_W'(1);
                if (cnt_ff >= wait_states(pcr1_ff[`SWWC_BIT_WW_HI:`SWWC_BIT_WW_LO]) - CNT_W'(1)) begin
                    nxt_mode = tgt_ff;
                    nxt_hold = 1'b0;
                    nxt_cnt = '0;
                end
            end
            default: begin
                nxt_mode = swwc_pkg::SWWC_ACTIVE;
                nxt_hold = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcr1_ff <= `SWWC_PCR_RESET;
            pcr2_ff <= `SWWC_PCR_RESET;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            mode_ff <= swwc_pkg::SWWC_ACTIVE;
            tgt_ff <= swwc_pkg::SWWC_ACTIVE;
            cnt_ff <= '0;
            hold_ff <= 1'b0;
        end else begin
            pcr1_ff <= nxt_pcr1;
            pcr2_ff <= nxt_pcr2;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            mode_ff <= nxt_mode;
            tgt_ff <= nxt_tgt;
            cnt_ff <= nxt_cnt;
            hold_ff <= nxt_hold;
        end
    end

    swwc_sampler u_sampler (
        .pclk(pclk),
        .presetn(presetn),
        .fast_rate(pcr1_ff[`SWWC_BIT_NSR]),
        .watch_clk_in(watch_clk_in),
        .watch_clk_sampled(samp_w),
        .sample_tick(tick_w)
    );

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign cpu_hold = hold_ff;
    assign mode_out = mode_ff;
    assign watch_clk_sampled = samp_w;
    assign sample_tick = tick_w;
endmodule : swwc_top

// [swwc_properties.sv]
`timescale 1ns/1ps
module swwc_checker #(
    parameter int unsigned CNT_W = 18
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic sleep_exec,
    input wire logic wake_irq,
    input wire logic cpu_hold,
    input wire logic [5:0] mode_out,
    input wire logic sample_tick
);
    logic [7:0] cfg_ff, nxt_cfg;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    // 2^(13+s) up to s=4, then 1024, 128, 16
    function automatic int nwait(input logic [2:0] s);
        return 1 << (s < 3'h5 ? 13 + s : 25 - 3 * s);
    endfunction : nwait
    always_comb begin
        nxt_cfg = cfg_ff;
        if (psel && !penable && pwrite && paddr == 12'h000) nxt_cfg = pwdata[7:0];
        nxt_cnt = cpu_hold ? cnt_ff + 1'b1 : '0;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= 8'h00;
            cnt_ff <= '0;
        end else begin
            cfg_ff <= nxt_cfg;
            cnt_ff <= nxt_cnt;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rsv; pready && !pwrite && paddr == 12'h000 |-> prdata == {24'h0, cfg_ff[7:3], 3'h0}; endproperty
    a_rsv: assert property (p_rsv) else $error("control read mismatch");
    property p_sby; sleep_exec && mode_out == 6'h01 && cfg_ff[7] |=> mode_out == 6'h08; endproperty
    a_sby: assert property (p_sby) else $error("standby not entered");
    property p_slp; sleep_exec && mode_out == 6'h01 && !cfg_ff[7] |=> mode_out != 6'h08; endproperty
    a_slp: assert property (p_slp) else $error("standby entered wrongly");
    property p_wait; mode_out == 6'h08 && wake_irq |=> cpu_hold && mode_out == 6'h20; endproperty
    a_wait: assert property (p_wait) else $error("no hold after wake");
    property p_len; $fell(cpu_hold) |-> int'(cnt_ff) == nwait(cfg_ff[6:4]); endproperty
    a_len: assert property (p_len) else $error("hold length wrong");
    property p_held; cpu_hold |-> mode_out == 6'h20; endproperty
    a_held: assert property (p_held) else $error("hold outside wait");
    property p_tick; sample_tick |=> !sample_tick [*3]; endproperty
    a_tick: assert property (p_tick) else $error("ticks too close");
    property p_mode; $onehot(mode_out); endproperty
    a_mode: assert property (p_mode) else $error("mode not one-hot");
    c_sby: cover property (mode_out == 6'h08);
    c_sub: cover property (mode_out == 6'h04);
    c_rel: cover property ($fell(cpu_hold));
endmodule : swwc_checker
bind swwc_top swwc_checker #(.CNT_W(CNT_W)) i_swwc_checker (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .sleep_exec, .wake_irq, .cpu_hold, .mode_out, .sample_tick);

// [testbench.sv]
`timescale 1ns/1ps
`define CK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module testbench;
    typedef struct {logic [7:0] c1; logic [7:0] c2; logic [5:0] m; int n; logic [5:0] f;} swwc_row_t;
    // an external clock source is modelled, so short waits are the recommended setting
    swwc_row_t rows[10] = '{'{8'h00, 8'h00, 6'h02, 0, 6'h01}, '{8'hf0, 8'h00, 6'h08, 16, 6'h01},
        '{8'h70, 8'h80, 6'h04, 16, 6'h01}, '{8'he0, 8'h00, 6'h08, 128, 6'h01}, '{8'hd0, 8'h00, 6'h08, 1024, 6'h01},
        '{8'h80, 8'h00, 6'h08, 8192, 6'h01}, '{8'h90, 8'h00, 6'h08, 16384, 6'h01},
        '{8'h70, 8'hc0, 6'h04, 16, 6'h10}, '{8'h70, 8'h20, 6'h01, 0, 6'h01}, '{8'h70, 8'h60, 6'h10, 0, 6'h10}};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_exec = 0, wake_irq = 0;
    logic watch_clk_in = 0, pready, pslverr, er, cpu_hold, watch_clk_sampled, sample_tick;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [5:0] mode_out;
    int n_errors = 0, cmp_count = 0, cyc = 0, n;
    swwc_top i_swwc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sleep_exec, .wake_irq, .watch_clk_in, .cpu_hold, .mode_out, .watch_clk_sampled, .sample_tick);
    initial forever #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        watch_clk_in <= cyc[4];
        if (cyc == 60000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic conclude();
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // counts settled cycles of hold after one wake pulse
    task automatic wake(output int k);
        wake_irq <= 1'b1;
        @(posedge pclk) wake_irq <= 1'b0;
        for (k = 0; k < 20000; k++) begin
            @(negedge pclk);
            if (cpu_hold !== 1'b1) break;
        end
        @(posedge pclk);
    endtask : wake
    // the first gap after a rate change may be cut short, so callers take the second
    task automatic gap(output int g);
        do @(negedge pclk); while (sample_tick !== 1'b1);
        g = 0;
        do begin
            @(negedge pclk);
            g++;
        end while (sample_tick !== 1'b1);
        @(posedge pclk);
    endtask : gap
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            apb(1'b1, 12'h004, {24'h0, rows[i].c2});
            apb(1'b1, 12'h000, {24'h0, rows[i].c1});
            sleep_exec <= 1'b1;
            @(posedge pclk) sleep_exec <= 1'b0;
            @(negedge pclk);
            `CK(mode_out, rows[i].m)
            @(posedge pclk);
            wake(n);
            `CK(n, rows[i].n)
            `CK(mode_out, rows[i].f)
        end
        // subactive with low speed cleared: a wake runs the wait, then active
        apb(1'b1, 12'h004, 32'h0);
        wake(n);
        `CK(n, 16)
        `CK(mode_out, 6'h01)
        // pclk is 20 MHz, outside 2 to 10 MHz, so the fast rate select is allowed
        apb(1'b1, 12'h000, 32'hffffffff);
        apb(1'b0, 12'h000, 32'h0);
        `CK(rd, 32'h000000f8)
        gap(n);
        gap(n);
        `CK(n, 4)
        // pin still for 13 cycles here, longer than sync plus one fast sample period
        repeat (2) begin
            do @(negedge pclk); while (cyc[3:0] != 4'he);
            `CK(watch_clk_sampled, watch_clk_in)
        end
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk) presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        `CK(rd, 32'h0)
        apb(1'b0, 12'h008, 32'h0);
        `CK(rd[5:0], 6'h01)
        gap(n);
        gap(n);
        `CK(n, 16)
        apb(1'b0, 12'h010, 32'h0);
        `CK({er, rd}, 33'h100000000)
        conclude();
    end
endmodule : testbench
